// File: ppc_profile_position.sv
// Profile position command handshake: flags, single-entry buffer, 1 ms sequencing.
// Assumes a trajectory generator outside that takes o_motion and reports
// arrival, window settling, feasibility and following error on plain inputs.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Block acts only while operating mode equals 1.
// - Bit 4 rising starts a move; already set on mode entry also starts.
// - Bit 5 set applies new command at once; clear queues it.
// - Bit 6 picks absolute or relative; option bits 0-1 pick reference.
// - Bit 8 halts; rise brakes per halt option, fall restarts ramp.
// - Bit 9 keeps speed through the intermediate target without braking.
// - Bit 9 set passes through; both clear finishes positioning first.
// - Bit 9 ignored when ramp speed cannot be met at target.
// - Bit 10 set after last target reached and window time met.
// - Bit 11 set while demand lies outside software limits.
// - Bit 12 follows the new-setpoint bit for valid setpoints.
// - Queued command clears bit 12 once accepted; commands while set are dropped.
// - Acknowledge withheld for unreachable target or pending queued target.
// - Bit 13 set on following error beyond window for timeout.
// - Host writes target then bit 4; device acks, moves, reports reached.
// - Device clears bit 4 itself when option bits 4 and 5 allow.
// - One further target with its parameters buffered; ack clears when free.
// - Setpoint dropped when buffer full; bit 5 bypasses buffer.
// - Bit 9 holds profile speed to target; else uses end velocity.
// - Position sampled each ms; relative base is last target with option bits 0-1 clear, else latest ms sample.
// - All inputs processed once per 1 ms cycle.
// - Absolute targets clamped; outside range only moves back are taken.
// - Jerk limits only with profile type 3; 0 means no jerk limit.
module ppc_profile_position
    import ppc_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [17:0]        wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               i_target_arrived,
    input  wire logic               i_in_window_timed,
    input  wire logic               i_ramp_speed_met,
    input  wire logic               i_reachable,
    input  wire logic               i_follow_error,
    input  wire logic               i_closed_loop,
    input  wire logic signed [31:0] i_actual_pos,
    output ppc_pkg::ppc_motion_t    o_motion,
    output logic                    o_busy
);
    import ppc_pkg::*;

    typedef struct packed {
        logic [15:0]        cmd;
        logic [15:0]        cmd_prev;
        logic [7:0]         op_mode;
        logic               was_pp;
        logic signed [31:0] target;
        logic signed [31:0] lim_min;
        logic signed [31:0] lim_max;
        logic [15:0]        pos_opt;
        logic [15:0]        profile;
        logic [1:0]         halt_opt;
        logic [31:0]        speed;
        logic [15:0]        tick_cnt;
        logic               ack;
        logic               reached;
        logic               limit;
        logic               follow;
        ppc_state_t         state;
        ppc_cmd_t           cur;
        ppc_cmd_t           buf_cmd;
        logic               buf_full;
        logic signed [31:0] base;
        logic signed [31:0] sample;
        ppc_motion_t        motion;
        logic               ack_r;
        logic [31:0]        rdata;
    } ppc_regs_t;

    ppc_regs_t r;
    ppc_regs_t next_r;

    // Pin-side inputs pass two flops before use
    // Position is a multi-bit word; it is only consumed at ticks, long after it settles
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic signed [31:0] pos1;
    logic signed [31:0] pos2;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            pos1  <= 32'sh0;
            pos2  <= 32'sh0;
        end
        else
        begin
            sync1 <= {i_target_arrived, i_in_window_timed, i_ramp_speed_met,
                      i_reachable, i_follow_error, i_closed_loop};
            sync2 <= sync1;
            pos1  <= i_actual_pos;
            pos2  <= pos1;
        end
    end

    wire logic arrived    = sync2[5];
    wire logic in_window  = sync2[4];
    wire logic speed_met  = sync2[3];
    wire logic reachable  = sync2[2];
    wire logic follow_err = sync2[1];
    wire logic closed     = sync2[0];

    // Ack is registered and blocks the next take, so each request gets one pulse
    wire logic        req     = wb_cyc_i && wb_stb_i && !r.ack_r;
    wire logic [15:0] idx     = wb_adr_i[17:2];
    wire logic [15:0] state_w = {2'b00, r.follow, r.ack, r.limit, r.reached, 10'h000};

    always_comb
    begin
        logic               tick;
        logic               in_pp;
        logic               rise4;
        logic               rise8;
        logic               fall8;
        logic signed [31:0] ref_pos;
        logic signed [31:0] tgt;
        logic               outside;
        logic               toward;
        logic               valid;
        ppc_cmd_t           newc;
        logic               launched;

        next_r = r;
        tick   = 1'b0;
        // Locals start from a known value on every pass
        in_pp    = 1'b0;
        rise4    = 1'b0;
        rise8    = 1'b0;
        fall8    = 1'b0;
        ref_pos  = 32'sh0;
        tgt      = 32'sh0;
        outside  = 1'b0;
        toward   = 1'b0;
        valid    = 1'b0;
        newc     = '0;
        launched = 1'b0;
        next_r.ack_r = req;
        next_r.motion.start = 1'b0;
        next_r.motion.halt_rise = 1'b0;
        next_r.motion.halt_fall = 1'b0;

        // Register access; state flags are read only
        if (req)
        begin
            next_r.rdata = 32'h0;
            if (idx == IDX_CMD_FLAGS)
            begin
                next_r.rdata = {16'h0, r.cmd};
                if (wb_we_i && wb_sel_i[0])
                    next_r.cmd[7:0] = wb_dat_i[7:0];
                if (wb_we_i && wb_sel_i[1])
                    next_r.cmd[15:8] = wb_dat_i[15:8];
            end
            else if (idx == IDX_STATE_FLAGS)
                next_r.rdata = {16'h0, state_w};
            else if (idx == IDX_OP_MODE)
            begin
                next_r.rdata = {24'h0, r.op_mode};
                if (wb_we_i && wb_sel_i[0])
                    next_r.op_mode = wb_dat_i[7:0];
            end
            else if (idx == IDX_TARGET)
            begin
                next_r.rdata = r.target;
                if (wb_we_i)
                    next_r.target = wb_dat_i;
            end
            else if (idx == IDX_LIM_MIN)
            begin
                next_r.rdata = r.lim_min;
                if (wb_we_i)
                    next_r.lim_min = wb_dat_i;
            end
            else if (idx == IDX_LIM_MAX)
            begin
                next_r.rdata = r.lim_max;
                if (wb_we_i)
                    next_r.lim_max = wb_dat_i;
            end
            else if (idx == IDX_POS_OPT)
            begin
                next_r.rdata = {16'h0, r.pos_opt};
                if (wb_we_i)
                    next_r.pos_opt = wb_dat_i[15:0];
            end
            else if (idx == IDX_PROFILE)
            begin
                next_r.rdata = {16'h0, r.profile};
                if (wb_we_i)
                    next_r.profile = wb_dat_i[15:0];
            end
            else if (idx == IDX_HALT_OPT)
            begin
                next_r.rdata = {30'h0, r.halt_opt};
                if (wb_we_i)
                    next_r.halt_opt = wb_dat_i[1:0];
            end
            else if (idx == IDX_SPEED)
            begin
                next_r.rdata = r.speed;
                if (wb_we_i)
                    next_r.speed = wb_dat_i;
            end
            else if (idx == IDX_ACTUAL)
                next_r.rdata = r.sample;
        end

        // Work happens once per millisecond, so faster changes are not seen
        if (r.tick_cnt == 16'(TICK_CYCLES - 1))
        begin
            next_r.tick_cnt = 16'h0;
            tick = 1'b1;
        end
        else
            next_r.tick_cnt = r.tick_cnt + 16'h1;

        in_pp = (r.op_mode == OP_MODE_PP);
        // Edges against the held copy of the previous tick
        rise4 = r.cmd[B_NEW_SP] && (!r.cmd_prev[B_NEW_SP] || !r.was_pp);
        rise8 = r.cmd[B_HALT] && !r.motion.halt;
        fall8 = !r.cmd[B_HALT] && r.motion.halt;

        // Relative reference: last target or the latest tick's position sample
        ref_pos = (r.pos_opt[1:0] == 2'b00) ? r.base : r.sample;
        tgt = r.cmd[B_REL] ? (ref_pos + r.target) : r.target;
        outside = (r.sample < r.lim_min) || (r.sample > r.lim_max);
        toward  = (r.sample < r.lim_min) ? (tgt > r.sample) : (tgt < r.sample);
        if (!r.cmd[B_REL])
        begin
            if (tgt < r.lim_min)
                tgt = r.lim_min;
            else if (tgt > r.lim_max)
                tgt = r.lim_max;
        end
        // Refused commands fall through with motion and buffer untouched
        valid = reachable && (!outside || toward);
        newc.target = tgt;
        newc.speed  = r.speed;
        newc.chain  = r.cmd[B_CHG_SP] && speed_met;

        if (tick)
        begin
            next_r.cmd_prev = r.cmd;
            next_r.was_pp = in_pp;
            next_r.sample = pos2;
            next_r.limit = in_pp && ((r.cur.target < r.lim_min)
                                     || (r.cur.target > r.lim_max));
            next_r.follow = in_pp && closed && follow_err;
            next_r.motion.jerk_en = (r.profile == PROFILE_JERK);
            next_r.motion.halt = in_pp && r.cmd[B_HALT];
            next_r.motion.halt_rise = in_pp && rise8;
            next_r.motion.halt_fall = in_pp && fall8;
            next_r.motion.halt_opt = r.halt_opt;

            if (in_pp)
            begin
                // Acknowledge drops with the setpoint bit once nothing waits
                if (!r.cmd[B_NEW_SP] && !r.buf_full)
                    next_r.ack = 1'b0;
                if (rise4 && valid && !r.ack)
                begin
                    if (r.state == ST_IDLE || r.cmd[B_IMMED])
                    begin
                        next_r.cur = newc;
                        next_r.motion.start = 1'b1;
                        next_r.motion.cmd = newc;
                        next_r.state = ST_MOVING;
                        next_r.reached = 1'b0;
                        next_r.ack = 1'b1;
                        launched = 1'b1;
                    end
                    else if (!r.buf_full)
                    begin
                        next_r.buf_cmd = newc;
                        next_r.buf_full = 1'b1;
                        next_r.ack = 1'b1;
                    end
                    // Self-clear lets the host raise bit 4 again without writing 0
                    if (r.pos_opt[5:4] != 2'b00)
                        next_r.cmd[B_NEW_SP] = 1'b0;
                end

                // A move launched this tick must not be retired by the old arrival
                if (r.state == ST_MOVING && arrived && !launched)
                begin
                    next_r.base = r.cur.target;
                    if (r.buf_full && (r.cur.chain || in_window))
                    begin
                        next_r.cur = r.buf_cmd;
                        next_r.motion.cmd = r.buf_cmd;
                        next_r.motion.start = 1'b1;
                        next_r.buf_full = 1'b0;
                        if (!r.cmd[B_NEW_SP])
                            next_r.ack = 1'b0;
                    end
                    else if (!r.buf_full && in_window)
                    begin
                        next_r.state = ST_IDLE;
                        next_r.reached = 1'b1;
                    end
                end
            end
            else
            begin
                // Leaving the mode drops any queued move and the acknowledge
                next_r.state = ST_IDLE;
                next_r.buf_full = 1'b0;
                next_r.ack = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // Limits open wide, so nothing is clamped until software sets them
            r.cmd      <= CMD_RESET;
            r.cmd_prev <= CMD_RESET;
            r.op_mode  <= OP_MODE_RESET;
            r.was_pp   <= 1'b0;
            r.target   <= 32'sh0;
            r.lim_min  <= LIM_MIN_RESET;
            r.lim_max  <= LIM_MAX_RESET;
            r.pos_opt  <= 16'h0000;
            r.profile  <= 16'h0000;
            r.halt_opt <= 2'b00;
            r.speed    <= 32'h0;
            r.tick_cnt <= 16'h0000;
            r.ack      <= 1'b0;
            r.reached  <= 1'b0;
            r.limit    <= 1'b0;
            r.follow   <= 1'b0;
            r.state    <= ST_IDLE;
            r.cur      <= '0;
            r.buf_cmd  <= '0;
            r.buf_full <= 1'b0;
            r.base     <= 32'sh0;
            r.sample   <= 32'sh0;
            r.motion   <= '0;
            r.ack_r    <= 1'b0;
            r.rdata    <= 32'h0;
        end
        else
            r <= next_r;
    end

    assign wb_ack_o = r.ack_r;
    assign wb_dat_o = r.rdata;
    assign o_motion = r.motion;
    assign o_busy   = (r.state == ST_MOVING);

endmodule
`default_nettype wire

// File: ppc_pkg.sv
// Package for the profile position command handshake block.
// Assumes a single 50 MHz clock domain and a classic Wishbone slave port.
package ppc_pkg;

    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_CMD_FLAGS   = 16'h6040;
    localparam logic [15:0] IDX_STATE_FLAGS = 16'h6041;
    localparam logic [15:0] IDX_OP_MODE     = 16'h6060;
    localparam logic [15:0] IDX_TARGET      = 16'h607a;
    localparam logic [15:0] IDX_LIM_MIN     = 16'h6100;
    localparam logic [15:0] IDX_LIM_MAX     = 16'h6101;
    localparam logic [15:0] IDX_POS_OPT     = 16'h60f2;
    localparam logic [15:0] IDX_PROFILE     = 16'h6086;
    localparam logic [15:0] IDX_HALT_OPT    = 16'h605d;
    localparam logic [15:0] IDX_SPEED       = 16'h6081;
    localparam logic [15:0] IDX_ACTUAL      = 16'h6064;
    localparam logic [17:0] ADDR_SHIFT_ZERO = 18'h00000;

    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic signed [31:0] LIM_MIN_RESET = 32'sh8000_0000;
    localparam logic signed [31:0] LIM_MAX_RESET = 32'sh7fff_ffff;
    localparam logic [7:0]  OP_MODE_RESET   = 8'h00;
    localparam logic [7:0]  OP_MODE_PP      = 8'h01;
    localparam logic [15:0] PROFILE_JERK    = 16'h0003;

    localparam int unsigned B_NEW_SP   = 4;
    localparam int unsigned B_IMMED    = 5;
    localparam int unsigned B_REL      = 6;
    localparam int unsigned B_HALT     = 8;
    localparam int unsigned B_CHG_SP   = 9;
    localparam int unsigned S_REACHED  = 10;
    localparam int unsigned S_LIMIT    = 11;
    localparam int unsigned S_ACK      = 12;
    localparam int unsigned S_FOLLOW   = 13;

    typedef struct packed {
        logic signed [31:0] target;
        logic [31:0]        speed;
        logic               chain;
    } ppc_cmd_t;

    typedef struct packed {
        logic               start;
        ppc_cmd_t           cmd;
        logic               halt;
        logic               halt_rise;
        logic               halt_fall;
        logic [1:0]         halt_opt;
        logic               jerk_en;
    } ppc_motion_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVING
    } ppc_state_t;

endpackage

// File: ppc_profile_position_monitor.sv
// Checker for the profile position block, bound to its ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ppc_profile_position_monitor
    import ppc_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [17:0]          wb_adr_i,
    input  wire logic [31:0]          wb_dat_o,
    input  wire logic                 wb_ack_o,
    input  wire ppc_pkg::ppc_motion_t o_motion,
    input  wire logic                 o_busy
);
    import ppc_pkg::*;
    int   gap;
    logic seen;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Cycles since the last start pulse, saturating so it never wraps
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            gap  <= 0;
            seen <= 1'b0;
        end
        else if (o_motion.start)
        begin
            gap  <= 0;
            seen <= 1'b1;
        end
        else if (gap < TICK_CYCLES)
            gap <= gap + 1;
    end
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    AST_START_PULSE: assert property (o_motion.start |=> !o_motion.start)
        else $error("start longer than one cycle");
    AST_TICK_GAP: assert property (o_motion.start && seen |-> gap >= TICK_CYCLES - 1)
        else $error("starts closer than one tick");
    AST_HALT_RISE: assert property (o_motion.halt_rise |-> o_motion.halt && !$past(o_motion.halt))
        else $error("halt rise pulse without halt edge");
    AST_HALT_FALL: assert property (o_motion.halt_fall |-> !o_motion.halt && $past(o_motion.halt))
        else $error("halt fall pulse without halt edge");
    AST_BUSY_START: assert property (o_motion.start |-> ##[0:1] o_busy)
        else $error("busy not raised by start");
    AST_STATE_RSVD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[17:2] == IDX_STATE_FLAGS
        |-> (wb_dat_o & ~32'h0000_3c00) == 32'h0)
        else $error("state flags show unused bits");
    AST_CMD_AT_START: assert property ($changed(o_motion.cmd) |-> o_motion.start)
        else $error("command changed without start");
endmodule
bind ppc_profile_position ppc_profile_position_monitor i_mon
(
    .i_clk(i_clk), .i_rstn(i_rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .o_motion(o_motion), .o_busy(o_busy)
);
`default_nettype wire

// File: ppc_traj_model.sv
// Trajectory side model: arrives a fixed time after each start pulse.
// Assumes the block's motion bundle and one clock.
`timescale 1ns/100ps
`default_nettype none
module ppc_traj_model
    import ppc_pkg::*;
#(
    parameter logic [15:0] ARRIVE_CYCLES = 16'h00c8
)
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire ppc_pkg::ppc_motion_t i_motion,
    output logic                      o_arrived,
    output logic                      o_window,
    output logic                      o_ramp_met,
    output logic                      o_reachable,
    output logic                      o_follow_err,
    output logic                      o_closed_loop,
    output logic signed [31:0]        o_actual_pos
);
    import ppc_pkg::*;
    logic [15:0] remain;
    // Settling is reported together with arrival, the simplest legal case
    assign o_window      = o_arrived;
    assign o_ramp_met    = 1'b1;
    assign o_reachable   = 1'b1;
    assign o_follow_err  = 1'b0;
    assign o_closed_loop = 1'b1;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_arrived    <= 1'b0;
            remain       <= 16'h0000;
            o_actual_pos <= 32'sh0;
        end
        else if (i_motion.start)
        begin
            o_arrived <= 1'b0;
            remain    <= ARRIVE_CYCLES;
        end
        else if (remain == 16'h0001)
        begin
            o_arrived    <= 1'b1;
            o_actual_pos <= i_motion.cmd.target;
            remain       <= 16'h0000;
        end
        else if (remain != 16'h0000)
            remain <= remain - 16'h0001;
    end
endmodule
`default_nettype wire

// File: ppc_profile_position_tb.sv
// Testbench for the profile position block over classic Wishbone.
// Assumes the trajectory model answers each start; runs about two ticks.
`timescale 1ns/100ps
`default_nettype none
module ppc_profile_position_tb;
    import ppc_pkg::*;
    typedef struct packed {
        logic        we;
        logic [15:0] idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } ppc_row_t;
    localparam ppc_row_t ROWS [17] = '{
        '{1'b0, IDX_CMD_FLAGS, 32'h0, 32'h0}, '{1'b0, IDX_STATE_FLAGS, 32'h0, 32'h0},
        '{1'b0, IDX_OP_MODE, 32'h0, 32'h0}, '{1'b1, IDX_STATE_FLAGS, 32'hffff_ffff, 32'h0},
        '{1'b0, IDX_STATE_FLAGS, 32'h0, 32'h0}, '{1'b1, 16'h0000, 32'h1234_5678, 32'h0},
        '{1'b0, 16'h0000, 32'h0, 32'h0}, '{1'b1, IDX_TARGET, 32'h0000_1388, 32'h0},
        '{1'b0, IDX_TARGET, 32'h0, 32'h0000_1388}, '{1'b1, IDX_LIM_MIN, 32'hffff_fc18, 32'h0},
        '{1'b1, IDX_LIM_MAX, 32'h0001_86a0, 32'h0}, '{1'b1, IDX_POS_OPT, 32'h0, 32'h0},
        '{1'b1, IDX_PROFILE, 32'h0000_0003, 32'h0}, '{1'b1, IDX_HALT_OPT, 32'h0000_0002, 32'h0},
        '{1'b1, IDX_OP_MODE, 32'h0000_0001, 32'h0}, '{1'b0, IDX_OP_MODE, 32'h0, 32'h0000_0001},
        '{1'b1, IDX_SPEED, 32'h0000_01f4, 32'h0}};
    logic               i_clk = 1'b0, i_rstn = 1'b0;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [17:0]        wb_adr_i = 18'h0;
    logic [3:0]         wb_sel_i = 4'h0;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
    logic               wb_ack_o, o_busy, arrived, window, ramp_met, reachable, ferr, cl;
    logic signed [31:0] actual_pos;
    ppc_motion_t        o_motion;
    int                 errors = 0, compares = 0, cycles = 0;
    ppc_profile_position i_ppc_profile_position (.i_clk(i_clk), .i_rstn(i_rstn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .i_target_arrived(arrived), .i_in_window_timed(window), .i_ramp_speed_met(ramp_met),
        .i_reachable(reachable), .i_follow_error(ferr), .i_closed_loop(cl),
        .i_actual_pos(actual_pos), .o_motion(o_motion), .o_busy(o_busy));
    ppc_traj_model i_ppc_traj_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_motion(o_motion),
        .o_arrived(arrived), .o_window(window), .o_ramp_met(ramp_met), .o_reachable(reachable),
        .o_follow_err(ferr), .o_closed_loop(cl), .o_actual_pos(actual_pos));
    initial
        forever #10 i_clk = ~i_clk;
    task automatic report_and_stop;
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic single cycle; holds everything until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdat);
        @(posedge i_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        do
            @(posedge i_clk);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Motion changes only at ticks, so the wait spans up to one tick
    task automatic wait_motion(input bit want_halt);
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while ((want_halt ? o_motion.halt_rise : o_motion.start) !== 1'b1 && n < 60000);
        if (n >= 60000)
        begin
            errors++;
            $display("[ERR] %0t no motion event", $time);
        end
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 120000)
        begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop;
        end
    end
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        foreach (ROWS[k])
        begin
            wb(ROWS[k].we, ROWS[k].idx, ROWS[k].wd, rd);
            if (!ROWS[k].we)
                chk(rd, ROWS[k].exp);
        end
        wb(1'b1, IDX_CMD_FLAGS, 32'h0000_0010, rd);
        wait_motion(1'b0);
        chk(o_motion.cmd.target, 32'h0000_1388);
        chk({31'h0, o_motion.jerk_en}, 32'h1);
        @(posedge i_clk);
        chk({31'h0, o_busy}, 32'h1);
        chk(o_motion.cmd.speed, 32'h0000_01f4);
        wb(1'b0, IDX_STATE_FLAGS, 32'h0, rd);
        chk(rd, 32'h0000_1000);
        // Drop the new-setpoint bit and halt before the next tick
        wb(1'b1, IDX_CMD_FLAGS, 32'h0000_0100, rd);
        wait_motion(1'b1);
        chk({30'h0, o_motion.halt_opt}, 32'h2);
        chk({31'h0, o_motion.halt}, 32'h1);
        wb(1'b0, IDX_STATE_FLAGS, 32'h0, rd);
        chk(rd, 32'h0000_0400);
        chk({31'h0, o_busy}, 32'h0);
        wb(1'b0, IDX_ACTUAL, 32'h0, rd);
        chk(rd, 32'h0000_1388);
        report_and_stop;
    end
endmodule
`default_nettype wire
